//--- bench/ext_bus_align_and_xfer_release_bench.sv
// Bench for the bus bridge: registers, lane steering, splitting, release
// AHB-Lite master and access requester here; far side is ext_mem_model
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module ext_bus_align_and_xfer_release_bench;
	logic clock = 1'b0, rst = 1'b1, hsel = 1'b1, hwrite = 1'b0, rom_enabled = 1'b0;
	logic mpx_addr_wide = 1'b0, acc_valid = 1'b0, acc_write = 1'b0, xfer_step_done = 1'b0;
	logic xfer_single_done = 1'b0, xfer_nop_after_vector = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0, acc_size = 2'h0;
	logic [2:0] hsize = 3'h2, acc_area = 3'h0, xfer_info_longs;
	logic [31:0] hwdata = 32'h0, acc_addr = 32'h0, acc_wdata = 32'h0, r, rd;
	logic [31:0] xfer_src_in = 32'h0, xfer_dst_in = 32'h0, hrdata, acc_rdata, ext_addr;
	logic [31:0] ext_wdata, ext_rdata, transfer_source_address, transfer_destination_address;
	logic [7:0] xfer_req = 8'h00, xfer_grant;
	logic [3:0] dly = 4'h0;
	logic hreadyout, hresp, acc_ready, acc_done, ext_write, ext_cycle, ext_cycle_done;
	logic write_strobe_lane3_n, write_strobe_lane2_n, write_strobe_lane1_n, write_strobe_lane0_n;
	logic byte_mask_lane3, byte_mask_lane2, byte_mask_lane1, byte_mask_lane0;
	logic xfer_bus_held, xfer_bus_release, xfer_short_info_mode, xfer_info_skip_allowed;
	wire logic hready = hreadyout;
	int n_errors = 0;
	int checks_done = 0;
	int base;
	ext_bus_bridge ext_bus_bridge_inst (.*);
	ext_mem_model ext_mem_model_inst (.*, .strobe_n({write_strobe_lane3_n,
		write_strobe_lane2_n, write_strobe_lane1_n, write_strobe_lane0_n}));
	always #2 clock = ~clock;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (n_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int t;
		t = 0;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do begin @(posedge clock); t++; end while (hready !== 1'b1 && t < 50);
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge clock); t++; end while (hready !== 1'b1 && t < 100);
		q = hrdata;
	endtask
	task automatic cfg(input logic [2:0] ar, input logic [1:0] wd, input logic le);
		ahb(1'b1, 12'h004, (32'(wd) << (16 + 2 * ar)) | (32'(le) << (2 * ar)), r);
	endtask
	task automatic access(input logic [2:0] ar, input logic [31:0] a, input logic [1:0] sz,
			input logic w, input logic [31:0] d);
		int t;
		t = 0;
		base = ext_mem_model_inst.n;
		acc_valid <= 1'b1;
		acc_area <= ar;
		acc_addr <= a;
		acc_size <= sz;
		acc_write <= w;
		acc_wdata <= d;
		do begin @(posedge clock); t++; end while (acc_ready !== 1'b1 && t < 50);
		acc_valid <= 1'b0;
		do begin @(posedge clock); t++; end while (acc_done !== 1'b1 && t < 200);
		check(32'(t < 200), 32'h1);
		rd = acc_rdata;
	endtask
	task automatic lane(input logic [2:0] ar, input logic [1:0] wd, input logic le,
			input logic [1:0] sz, input logic [31:0] a, input logic [3:0] sn);
		logic [31:0] m;
		m = {{8{~sn[3]}}, {8{~sn[2]}}, {8{~sn[1]}}, {8{~sn[0]}}};
		cfg(ar, wd, le);
		access(ar, a, sz, 1'b1, 32'h5A5A5A5A);
		check(32'(ext_mem_model_inst.n - base), 32'h1);
		check({28'h0, ext_mem_model_inst.log_strb[base % 8]}, {28'h0, sn});
		check(ext_mem_model_inst.log_data[base % 8] & m, 32'h5A5A5A5A & m);
	endtask
	task automatic multi(input logic [1:0] wd, input logic le, input int nb,
			input logic [31:0] ex);
		logic [31:0] s;
		int i;
		int k;
		cfg(3'h1, wd, le);
		access(3'h1, 32'h00000100, `EXT_SIZE_LONG, 1'b1, 32'h11223344);
		check(32'(ext_mem_model_inst.n - base), 32'(nb));
		s = 32'h0;
		k = 32 / nb;
		for (i = 0; i < nb; i++) begin
			s = (s << k) | (ext_mem_model_inst.log_data[(base + i) % 8] & ((32'h1 << k) - 1));
			check(ext_mem_model_inst.log_addr[(base + i) % 8], 32'h100 + 32'(i * 4 / nb));
		end
		check(s, ex);
	endtask
	task automatic reg_test;
		ahb(1'b0, 12'h000, 32'h0, r);
		check(r, 32'h0);
		ahb(1'b1, 12'h000, 32'hFFFFFFFF, r);
		ahb(1'b0, 12'h000, 32'h0, r);
		check(r, 32'h00008D00);
		ahb(1'b0, 12'h00C, 32'h0, r);
		check(r, 32'h0);
		ahb(1'b1, 12'h000, 32'h0, r);
	endtask
	task automatic mode_test;
		xfer_src_in <= 32'h12345678;
		xfer_dst_in <= 32'h9ABCDEF0;
		ahb(1'b1, 12'h000, 32'h00000500, r);
		@(posedge clock);
		check(32'(xfer_info_longs), 32'h3);
		check(transfer_source_address, 32'hFF345678);
		check(transfer_destination_address, 32'hFFBCDEF0);
		check(32'(xfer_info_skip_allowed), 32'h0);
		ahb(1'b1, 12'h000, 32'h0, r);
		@(posedge clock);
		check(32'(xfer_info_longs), 32'h4);
		check(transfer_source_address, 32'h12345678);
	endtask
	task automatic lane_test;
		lane(3'h1, `EXT_WIDTH_32, 1'b0, `EXT_SIZE_BYTE, 32'h0, 4'h7);
		lane(3'h1, `EXT_WIDTH_32, 1'b0, `EXT_SIZE_BYTE, 32'h1, 4'hB);
		lane(3'h1, `EXT_WIDTH_32, 1'b0, `EXT_SIZE_BYTE, 32'h3, 4'hE);
		lane(3'h1, `EXT_WIDTH_32, 1'b0, `EXT_SIZE_WORD, 32'h2, 4'hC);
		lane(3'h1, `EXT_WIDTH_32, 1'b0, `EXT_SIZE_LONG, 32'h0, 4'h0);
		lane(3'h1, `EXT_WIDTH_32, 1'b1, `EXT_SIZE_BYTE, 32'h0, 4'hE);
		lane(3'h1, `EXT_WIDTH_32, 1'b1, `EXT_SIZE_BYTE, 32'h3, 4'h7);
		lane(3'h1, `EXT_WIDTH_32, 1'b1, `EXT_SIZE_WORD, 32'h0, 4'hC);
		lane(3'h1, `EXT_WIDTH_32, 1'b1, `EXT_SIZE_WORD, 32'h2, 4'h3);
		lane(3'h1, `EXT_WIDTH_16, 1'b0, `EXT_SIZE_BYTE, 32'h0, 4'hD);
		lane(3'h1, `EXT_WIDTH_16, 1'b0, `EXT_SIZE_BYTE, 32'h1, 4'hE);
		lane(3'h1, `EXT_WIDTH_16, 1'b1, `EXT_SIZE_BYTE, 32'h0, 4'hE);
		lane(3'h1, `EXT_WIDTH_16, 1'b1, `EXT_SIZE_BYTE, 32'h1, 4'hD);
		lane(3'h1, `EXT_WIDTH_8, 1'b0, `EXT_SIZE_BYTE, 32'h1, 4'hE);
		lane(3'h1, `EXT_WIDTH_8, 1'b1, `EXT_SIZE_BYTE, 32'h2, 4'hE);
		lane(3'h0, `EXT_WIDTH_32, 1'b1, `EXT_SIZE_BYTE, 32'h0, 4'h7);
		rom_enabled <= 1'b1;
		lane(3'h0, `EXT_WIDTH_32, 1'b1, `EXT_SIZE_BYTE, 32'h0, 4'hE);
	endtask
	task automatic split_test;
		dly <= 4'h2;
		multi(`EXT_WIDTH_8, 1'b0, 4, 32'h11223344);
		multi(`EXT_WIDTH_8, 1'b1, 4, 32'h44332211);
		multi(`EXT_WIDTH_16, 1'b0, 2, 32'h11223344);
		multi(`EXT_WIDTH_16, 1'b1, 2, 32'h33441122);
		multi(`EXT_WIDTH_MPX, 1'b0, 4, 32'h11223344);
		mpx_addr_wide <= 1'b1;
		multi(`EXT_WIDTH_MPX, 1'b0, 2, 32'h11223344);
		cfg(3'h1, `EXT_WIDTH_8, 1'b0);
		access(3'h1, 32'h00000100, `EXT_SIZE_LONG, 1'b0, 32'h0);
		check(rd, 32'h40414243);
		cfg(3'h1, `EXT_WIDTH_8, 1'b1);
		access(3'h1, 32'h00000100, `EXT_SIZE_LONG, 1'b0, 32'h0);
		check(rd, 32'h43424140);
		dly <= 4'h0;
	endtask
	task automatic rel_run(input logic [31:0] v, input int lo, input int hi);
		int t;
		int rel;
		rel = 0;
		ahb(1'b1, 12'h000, v, r);
		xfer_req <= 8'h03;
		for (t = 0; t < 90; t++) begin
			@(posedge clock);
			xfer_req <= 8'h00;
			xfer_step_done <= (t > 5 && t % 3 == 0);
			xfer_single_done <= (t > 5 && t % 3 == 0);
			if (xfer_bus_release === 1'b1)
				rel++;
		end
		check(32'(rel >= lo && rel <= hi), 32'h1);
	endtask
	task automatic release_test;
		rel_run(32'h00000000, 2, 2);
		rel_run(32'h00000800, 1, 1);
		rel_run(32'h00008000, 3, 20);
	endtask
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		reg_test();
		mode_test();
		lane_test();
		split_test();
		release_test();
		tally_and_finish();
	end
	// Whole run is several hundred cycles
	initial begin
		#40000;
		n_errors++;
		tally_and_finish();
	end
endmodule

//--- bench/ext_bus_bridge_sva.sv
// Checker for the bus bridge: strobes, masks, beat start, address forcing
// Bound to every ext_bus_bridge; one clock, synchronous reset
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module ext_bus_bridge_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic acc_valid,
	input wire logic acc_ready,
	input wire logic acc_done,
	input wire logic [31:0] acc_addr,
	input wire logic [31:0] ext_addr,
	input wire logic ext_write,
	input wire logic ext_cycle,
	input wire logic write_strobe_lane3_n,
	input wire logic write_strobe_lane2_n,
	input wire logic write_strobe_lane1_n,
	input wire logic write_strobe_lane0_n,
	input wire logic byte_mask_lane3,
	input wire logic byte_mask_lane2,
	input wire logic byte_mask_lane1,
	input wire logic byte_mask_lane0,
	input wire logic [`EXT_NUM_REQ-1:0] xfer_grant,
	input wire logic xfer_bus_held,
	input wire logic xfer_bus_release,
	input wire logic [2:0] xfer_info_longs,
	input wire logic xfer_short_info_mode,
	input wire logic [31:0] xfer_src_in,
	input wire logic [31:0] xfer_dst_in,
	input wire logic [31:0] transfer_source_address,
	input wire logic [31:0] transfer_destination_address
);
	wire logic [3:0] sn = {write_strobe_lane3_n, write_strobe_lane2_n,
		write_strobe_lane1_n, write_strobe_lane0_n};
	wire logic [3:0] mk = {byte_mask_lane3, byte_mask_lane2, byte_mask_lane1, byte_mask_lane0};
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_strobe_write_only: assert property ((!ext_write || !ext_cycle) |-> sn == 4'hF)
		else $error("write strobe outside a write beat");
	a_mask_idle: assert property (!ext_cycle |-> mk == 4'hF)
		else $error("byte mask active between beats");
	a_strobe_mask_lane: assert property (ext_cycle && ext_write |-> sn == mk)
		else $error("strobe and mask lanes differ");
	a_accept_beat: assert property (acc_valid && acc_ready |=>
		!acc_ready && ext_cycle && ext_addr == $past(acc_addr))
		else $error("accepted access did not start its first beat");
	a_short_top: assert property (xfer_short_info_mode |->
		transfer_source_address == {8'hFF, xfer_src_in[23:0]} &&
		transfer_destination_address == {8'hFF, xfer_dst_in[23:0]})
		else $error("short mode address top byte wrong");
	a_plain_addr: assert property (!xfer_short_info_mode |->
		transfer_source_address == xfer_src_in && transfer_destination_address == xfer_dst_in)
		else $error("normal mode address altered");
	a_info_longs: assert property (xfer_info_longs == (xfer_short_info_mode ? 3'h3 : 3'h4))
		else $error("info longword count wrong");
	a_grant_held: assert property (xfer_bus_held |-> $onehot(xfer_grant))
		else $error("grant not one-hot while bus held");
	c_done: cover property (acc_done && ext_write);
	c_release: cover property (xfer_bus_release);
	c_short: cover property (xfer_short_info_mode);
endmodule
bind ext_bus_bridge ext_bus_bridge_sva ext_bus_bridge_sva_inst (.*);

//--- bench/ext_mem_model.sv
// Far-side memory: ends each beat after dly+1 cycles, logs beats seen
// Read lanes follow the beat address; inverse of last value between beats
`timescale 1ns/1ps
module ext_mem_model (
	input wire logic clock,
	input wire logic ext_cycle,
	input wire logic [31:0] ext_addr,
	input wire logic [31:0] ext_wdata,
	input wire logic [3:0] strobe_n,
	input wire logic [3:0] dly,
	output logic ext_cycle_done,
	output logic [31:0] ext_rdata
);
	int n = 0;
	int w = 0;
	logic [31:0] log_addr [8];
	logic [31:0] log_data [8];
	logic [3:0] log_strb [8];
	initial ext_cycle_done = 1'b0;
	initial ext_rdata = 32'h00000000;
	always @(posedge clock) begin
		ext_cycle_done <= 1'b0;
		if (ext_cycle && !ext_cycle_done) begin
			ext_rdata <= {4{8'h40 + ext_addr[7:0]}};
			if (w == int'(dly)) begin
				ext_cycle_done <= 1'b1;
				log_addr[n % 8] <= ext_addr;
				log_data[n % 8] <= ext_wdata;
				log_strb[n % 8] <= strobe_n;
				n <= n + 1;
				w <= 0;
			end else begin
				w <= w + 1;
			end
		end else begin
			// Stale data would hide a missed beat
			ext_rdata <= ~ext_rdata;
		end
	end
endmodule

//--- src/ext_bus_bridge.sv
// Bus bridge: AHB-Lite register slave, access splitter, transfer release control
// Assumes one AHB-Lite master, single aligned word transfers, one clock
`timescale 1ns/1ps
`include "ext_bus_map.svh"
// Function
// - Lock clear: release at nop or write-back
// - Lock set: release after every step
// - Burst clear: release after each request
// - Burst set, lock clear: hold bus until none pending
// - Short mode reads three longwords, else four
// - Short mode forces top address byte ones
// - Priority bit: arrival order or fixed priority
// - Priority mode never skips info read
// - Reserved extension bits read zero
// - Areas 1-7 use own byte order
// - Area 0 order ignored without ROM
// - Widths 8, 16, 32 supported
// - Multiplexed space fixed or address-picked width
// - Wide accesses split into narrower beats
// - 32-bit big endian lane order
// - 16-bit big endian lanes, two beats per longword
// - 8-bit big endian, MSB first
// - 32-bit little endian lane order
// - 16-bit little endian, low half first
// - 8-bit little endian, LSB first
module ext_bus_bridge (
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rom_enabled,
	input wire logic mpx_addr_wide,
	input wire logic acc_valid,
	output logic acc_ready,
	input wire logic [2:0] acc_area,
	input wire logic [31:0] acc_addr,
	input wire logic [1:0] acc_size,
	input wire logic acc_write,
	input wire logic [31:0] acc_wdata,
	output logic [31:0] acc_rdata,
	output logic acc_done,
	output logic [31:0] ext_addr,
	output logic [31:0] ext_wdata,
	output logic ext_write,
	output logic ext_cycle,
	input wire logic ext_cycle_done,
	input wire logic [31:0] ext_rdata,
	output logic write_strobe_lane3_n,
	output logic write_strobe_lane2_n,
	output logic write_strobe_lane1_n,
	output logic write_strobe_lane0_n,
	output logic byte_mask_lane3,
	output logic byte_mask_lane2,
	output logic byte_mask_lane1,
	output logic byte_mask_lane0,
	input wire logic [`EXT_NUM_REQ-1:0] xfer_req,
	input wire logic xfer_step_done,
	input wire logic xfer_nop_after_vector,
	input wire logic xfer_single_done,
	output logic [`EXT_NUM_REQ-1:0] xfer_grant,
	output logic xfer_bus_held,
	output logic xfer_bus_release,
	output logic [2:0] xfer_info_longs,
	output logic xfer_short_info_mode,
	output logic xfer_info_skip_allowed,
	input wire logic [31:0] xfer_src_in,
	input wire logic [31:0] xfer_dst_in,
	output logic [31:0] transfer_source_address,
	output logic [31:0] transfer_destination_address
);
	logic [15:0] bus_function_extension;
	logic [15:0] area_endian;
	logic [15:0] area_width;
	logic wr_pend;
	logic [11:0] wr_addr;
	logic [7:0] req_sync1;
	logic [7:0] req_sync2;
	logic [7:0] pending;
	logic [7:0] arrival;
	logic [2:0] active_req;
	ext_bus_pkg::xfer_state_t xs;
	ext_bus_pkg::xfer_state_t next_xs;
	ext_bus_pkg::beat_state_t bs;
	logic [31:0] base_addr;
	logic [31:0] wdata_hold;
	logic [31:0] rdata_acc;
	logic [1:0] size_hold;
	logic [1:0] width_hold;
	logic little_hold;
	logic write_hold;
	logic [1:0] beat_cnt;
	logic [1:0] beat_last;
	wire lock_en = bus_function_extension[`EXT_BIT_LOCK];
	wire burst_en = bus_function_extension[`EXT_BIT_BURST];
	wire prio_en = bus_function_extension[`EXT_BIT_PRIO];
	wire addr_phase = hsel && hready && htrans[1];
	wire wr_func = wr_pend && wr_addr == `EXT_OFF_FUNC_EXT;
	wire wr_area = wr_pend && wr_addr == `EXT_OFF_AREA_CFG;
	wire [1:0] acc_width_raw = area_width[2*acc_area +: 2];
	wire [1:0] acc_width = acc_width_raw == `EXT_WIDTH_MPX
		? (mpx_addr_wide ? `EXT_WIDTH_16 : `EXT_WIDTH_8) : acc_width_raw;
	wire acc_little = (acc_area == 3'h0 && !rom_enabled) ? 1'b0 : area_endian[2*acc_area];
	// beats needed, less one, per size and width
	wire [1:0] beats_m1 = acc_width == `EXT_WIDTH_32 ? 2'h0
		: acc_width == `EXT_WIDTH_16 ? (acc_size == `EXT_SIZE_LONG ? 2'h1 : 2'h0)
		: (acc_size == `EXT_SIZE_LONG ? 2'h3 : acc_size == `EXT_SIZE_WORD ? 2'h1 : 2'h0);
	wire [1:0] beat_size = width_hold == `EXT_WIDTH_32 ? size_hold
		: width_hold == `EXT_WIDTH_16 ? (size_hold == `EXT_SIZE_BYTE ? `EXT_SIZE_BYTE
		: `EXT_SIZE_WORD) : `EXT_SIZE_BYTE;
	wire [1:0] beat_step = width_hold == `EXT_WIDTH_16 ? {beat_cnt[0], 1'b0} : beat_cnt;
	wire [31:0] beat_addr = base_addr + {30'h0, beat_step};
	wire [1:0] slice = little_hold ? beat_cnt : beat_last - beat_cnt;
	wire [31:0] beat_wdata = width_hold == `EXT_WIDTH_16 ? {16'h0000, wdata_hold[16*slice[0] +: 16]}
		: width_hold == `EXT_WIDTH_32 ? wdata_hold : {24'h00_0000, wdata_hold[8*slice +: 8]};
	wire [31:0] lane_data;
	wire [3:0] lane_strobe;
	wire [31:0] read_slice = width_hold == `EXT_WIDTH_32 ? ext_rdata
		: width_hold == `EXT_WIDTH_16 ? {16'h0000, ext_rdata[15:0]} : {24'h00_0000, ext_rdata[7:0]};
	wire [31:0] read_merge = width_hold == `EXT_WIDTH_32 ? read_slice
		: width_hold == `EXT_WIDTH_16 ? (slice[0] ? {read_slice[15:0], rdata_acc[15:0]}
		: {rdata_acc[31:16], read_slice[15:0]})
		: (rdata_acc & ~(32'h0000_00FF << {slice, 3'h0})) | (read_slice << {slice, 3'h0});
	// Status packs 17 bits, so 15 leading zeros fill the word
	wire [31:0] rd_mux = haddr == `EXT_OFF_FUNC_EXT ? {16'h0000, bus_function_extension}
		: haddr == `EXT_OFF_AREA_CFG ? {area_width, area_endian}
		: haddr == `EXT_OFF_STATUS ? {15'h0000, pending, 2'h0, xfer_bus_held, xs, active_req}
		: 32'h0000_0000;
	ext_lane_steer steer (
		.beat_addr(beat_addr[1:0]),
		.beat_size(beat_size),
		.width(width_hold),
		.little(little_hold),
		.beat_data(beat_wdata),
		.lane_data(lane_data),
		.lane_strobe(lane_strobe)
	);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
		end else begin
			wr_pend <= addr_phase && hwrite;
			wr_addr <= haddr;
		end
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= rd_mux;
		end
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			bus_function_extension <= `EXT_FUNC_EXT_RESET;
			area_endian <= `EXT_AREA_CFG_RESET;
			area_width <= `EXT_AREA_CFG_RESET;
		end else begin
			if (wr_func)
				bus_function_extension <= hwdata[15:0] & `EXT_FUNC_EXT_WMASK;
			if (wr_area) begin
				area_endian <= hwdata[15:0];
				area_width <= hwdata[31:16];
			end
		end
	end
	// Requests arrive from other logic; synced as pins to be safe
	always_ff @(posedge clock) begin
		if (rst) begin
			req_sync1 <= 8'h00;
			req_sync2 <= 8'h00;
		end else begin
			req_sync1 <= xfer_req;
			req_sync2 <= req_sync1;
		end
	end
	// Finishing request is no candidate, else burst repeats it
	wire finish = (xs == ext_bus_pkg::XS_WBACK && xfer_step_done) || xs == ext_bus_pkg::XS_NOP;
	wire [7:0] done_mask = (finish ? 8'h01 : 8'h00) << active_req;
	wire [7:0] avail = pending & ~done_mask;
	logic [2:0] pick;
	logic pick_ok;
	always_comb begin
		pick = 3'h0;
		pick_ok = 1'b0;
		for (int i = `EXT_NUM_REQ - 1; i >= 0; i--) begin
			if (avail[i] && (prio_en || !pick_ok || arrival[i])) begin
				pick = 3'(i);
				pick_ok = 1'b1;
			end
		end
	end
	wire more = |(pending & ~(8'h01 << active_req));
	// release points by lock bit
	// Unlocked release as write-back ends or at nop; with burst set, only once none pending
	wire rel_step = lock_en ? xfer_step_done : finish;
	always_comb begin
		next_xs = xs;
		case (xs)
			ext_bus_pkg::XS_IDLE: next_xs = pick_ok ? ext_bus_pkg::XS_VECTOR : xs;
			ext_bus_pkg::XS_VECTOR: if (xfer_nop_after_vector) begin
				next_xs = ext_bus_pkg::XS_NOP;
			end else if (xfer_step_done) begin
				next_xs = ext_bus_pkg::XS_INFO;
			end
			ext_bus_pkg::XS_INFO: next_xs = xfer_step_done ? ext_bus_pkg::XS_DATA : xs;
			ext_bus_pkg::XS_DATA: next_xs = xfer_single_done ? ext_bus_pkg::XS_WBACK : xs;
			ext_bus_pkg::XS_WBACK: begin
				if (xfer_step_done)
					next_xs = (burst_en && more) ? ext_bus_pkg::XS_VECTOR : ext_bus_pkg::XS_IDLE;
			end
			ext_bus_pkg::XS_NOP: next_xs = ext_bus_pkg::XS_IDLE;
			default: next_xs = ext_bus_pkg::XS_IDLE;
		endcase
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			xs <= ext_bus_pkg::XS_IDLE;
			pending <= 8'h00;
			arrival <= 8'h00;
			active_req <= 3'h0;
			xfer_bus_release <= 1'b0;
		end else begin
			xs <= next_xs;
			// Set wins over the service clear
			pending <= avail | req_sync2;
			arrival <= pending == 8'h00 ? req_sync2 : arrival & pending;
			if (xs == ext_bus_pkg::XS_IDLE && pick_ok)
				active_req <= pick;
			else if (xs == ext_bus_pkg::XS_WBACK && xfer_step_done && burst_en && more)
				active_req <= pick;
			xfer_bus_release <= xs != ext_bus_pkg::XS_IDLE && (xs == ext_bus_pkg::XS_VECTOR
				? (lock_en ? xfer_step_done : 1'b0) : rel_step && (!burst_en || !more || lock_en));
		end
	end
	assign xfer_bus_held = xs != ext_bus_pkg::XS_IDLE;
	assign xfer_grant = xfer_bus_held ? (8'h01 << active_req) : 8'h00;
	assign xfer_info_longs = bus_function_extension[`EXT_BIT_SHORT]
		? `EXT_INFO_LONGS_SHORT : `EXT_INFO_LONGS_NORMAL;
	assign xfer_short_info_mode = bus_function_extension[`EXT_BIT_SHORT];
	assign xfer_info_skip_allowed = !prio_en;
	// top byte forced in short mode
	assign transfer_source_address = xfer_short_info_mode
		? {`EXT_SHORT_TOP, xfer_src_in[23:0]} : xfer_src_in;
	assign transfer_destination_address = xfer_short_info_mode
		? {`EXT_SHORT_TOP, xfer_dst_in[23:0]} : xfer_dst_in;
	always_ff @(posedge clock) begin
		if (rst) begin
			bs <= ext_bus_pkg::BS_IDLE;
			base_addr <= 32'h0000_0000;
			wdata_hold <= 32'h0000_0000;
			rdata_acc <= 32'h0000_0000;
			size_hold <= `EXT_SIZE_BYTE;
			width_hold <= `EXT_WIDTH_8;
			little_hold <= 1'b0;
			write_hold <= 1'b0;
			beat_cnt <= 2'h0;
			beat_last <= 2'h0;
			acc_rdata <= 32'h0000_0000;
		end else begin
			case (bs)
				ext_bus_pkg::BS_IDLE: if (acc_valid) begin
					base_addr <= acc_addr;
					wdata_hold <= acc_wdata;
					rdata_acc <= 32'h0000_0000;
					size_hold <= acc_size;
					width_hold <= acc_width;
					little_hold <= acc_little;
					write_hold <= acc_write;
					beat_cnt <= 2'h0;
					beat_last <= beats_m1;
					bs <= ext_bus_pkg::BS_CYCLE;
				end
				ext_bus_pkg::BS_CYCLE: if (ext_cycle_done) begin
					rdata_acc <= read_merge;
					if (beat_cnt == beat_last) begin
						acc_rdata <= read_merge;
						bs <= ext_bus_pkg::BS_DONE;
					end else begin
						beat_cnt <= beat_cnt + 2'h1;
					end
				end
				ext_bus_pkg::BS_DONE: bs <= ext_bus_pkg::BS_IDLE;
				default: bs <= ext_bus_pkg::BS_IDLE;
			endcase
		end
	end
	assign acc_ready = bs == ext_bus_pkg::BS_IDLE;
	assign acc_done = bs == ext_bus_pkg::BS_DONE;
	assign ext_cycle = bs == ext_bus_pkg::BS_CYCLE;
	assign ext_addr = beat_addr;
	assign ext_write = write_hold;
	assign ext_wdata = lane_data;
	wire [3:0] lanes_on = ext_cycle ? lane_strobe : 4'h0;
	assign write_strobe_lane3_n = !(lanes_on[3] && write_hold);
	assign write_strobe_lane2_n = !(lanes_on[2] && write_hold);
	assign write_strobe_lane1_n = !(lanes_on[1] && write_hold);
	assign write_strobe_lane0_n = !(lanes_on[0] && write_hold);
	assign byte_mask_lane3 = !lanes_on[3];
	assign byte_mask_lane2 = !lanes_on[2];
	assign byte_mask_lane1 = !lanes_on[1];
	assign byte_mask_lane0 = !lanes_on[0];
endmodule

//--- src/ext_bus_map.svh
// Register offsets, field positions, reset values and codes of the bus bridge
// Included by the main module, lane steering, checker and bench; definitions only
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH
`define EXT_OFF_FUNC_EXT 12'h000
`define EXT_OFF_AREA_CFG 12'h004
`define EXT_OFF_STATUS 12'h008
`define EXT_FUNC_EXT_RESET 16'h0000
`define EXT_FUNC_EXT_WMASK 16'h8D00
`define EXT_BIT_LOCK 15
`define EXT_BIT_BURST 11
`define EXT_BIT_SHORT 10
`define EXT_BIT_PRIO 8
`define EXT_AREA_CFG_RESET 16'h0000
`define EXT_SIZE_BYTE 2'h0
`define EXT_SIZE_WORD 2'h1
`define EXT_SIZE_LONG 2'h2
`define EXT_WIDTH_8 2'h0
`define EXT_WIDTH_16 2'h1
`define EXT_WIDTH_32 2'h2
`define EXT_WIDTH_MPX 2'h3
`define EXT_INFO_LONGS_NORMAL 3'h4
`define EXT_INFO_LONGS_SHORT 3'h3
`define EXT_SHORT_TOP 8'hFF
`define EXT_NUM_REQ 8
`endif

//--- src/ext_bus_pkg.sv
// Types shared by the bus bridge modules
// Codes written as literals; does not use ext_bus_map.svh
package ext_bus_pkg;
	typedef enum logic [2:0] {
		XS_IDLE = 3'h0,
		XS_VECTOR = 3'h1,
		XS_INFO = 3'h3,
		XS_DATA = 3'h2,
		XS_WBACK = 3'h6,
		XS_NOP = 3'h7
	} xfer_state_t;
	typedef enum logic [1:0] {
		BS_IDLE = 2'h0,
		BS_CYCLE = 2'h1,
		BS_DONE = 2'h3
	} beat_state_t;
endpackage

//--- src/ext_lane_steer.sv
// Lane steering for one external beat: data, write strobes, byte masks
// Pure combinational; caller supplies beat address, size and width
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module ext_lane_steer (
	input wire logic [1:0] beat_addr,
	input wire logic [1:0] beat_size,
	input wire logic [1:0] width,
	input wire logic little,
	input wire logic [31:0] beat_data,
	output logic [31:0] lane_data,
	output logic [3:0] lane_strobe
);
	logic [1:0] lane_pos;
	logic [3:0] one_lane;
	always_comb begin
		lane_pos = 2'h0;
		lane_data = 32'h0000_0000;
		lane_strobe = 4'h0;
		one_lane = 4'h0;
		case (width)
			`EXT_WIDTH_32: begin
				lane_pos = little ? beat_addr : ~beat_addr;
				if (beat_size == `EXT_SIZE_LONG) begin
					lane_data = beat_data;
					lane_strobe = 4'hF;
				end else if (beat_size == `EXT_SIZE_WORD) begin
					lane_data = (beat_addr[1] ^ ~little) ? {beat_data[15:0], 16'h0000}
						: {16'h0000, beat_data[15:0]};
					lane_strobe = (beat_addr[1] ^ ~little) ? 4'hC : 4'h3;
				end else begin
					one_lane[lane_pos] = 1'b1;
					lane_strobe = one_lane;
					lane_data = {4{beat_data[7:0]}};
				end
			end
			`EXT_WIDTH_16, `EXT_WIDTH_MPX: begin
				if (beat_size == `EXT_SIZE_BYTE) begin
					lane_strobe = (beat_addr[0] ^ little) ? 4'h1 : 4'h2;
					lane_data = {16'h0000, beat_data[7:0], beat_data[7:0]};
				end else begin
					lane_strobe = 4'h3;
					lane_data = {16'h0000, beat_data[15:0]};
				end
			end
			default: begin
				lane_strobe = 4'h1;
				lane_data = {24'h00_0000, beat_data[7:0]};
			end
		endcase
	end
endmodule
